// ===== rtc_wd_pkg.sv
// Constants, field layout and state types of the timeout and supply block.
// Assumes a single 50 MHz clock and a synchronous, active-high reset.
package rtc_wd_pkg;
  // ---------------------------------------------------------------
  // Clock and time base
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned TICK_PER_S = 16;
  localparam int unsigned TICK_CYC   = CLK_HZ / TICK_PER_S;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned REC_MS     = 2;
  localparam int unsigned RPU_MS     = 200;

  // ---------------------------------------------------------------
  // Register offsets on the parallel clock port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_FLAGS   = 4'h0;
  localparam logic [3:0] ADDR_INTR    = 4'h6;
  localparam logic [3:0] ADDR_TIMEOUT = 4'h7;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_TIMEOUT_BIT = 7;
  localparam int unsigned FLAG_ALARM_BIT   = 6;
  localparam int unsigned INTR_AE_BIT      = 7;
  localparam int unsigned INTR_ABE_BIT     = 6;
  localparam int unsigned TO_STEER_BIT     = 7;
  localparam int unsigned TO_MULT_LSB      = 2;
  localparam int unsigned TO_MULT_W        = 5;
  localparam int unsigned TO_RES_LSB       = 0;
  localparam logic [7:0]  TIMEOUT_RST      = 8'h00;

  // Resolution steps counted in sixteenth-second ticks
  typedef enum logic [1:0] {
    RES_SIXTEENTH = 2'h0,
    RES_QUARTER   = 2'h1,
    RES_ONE       = 2'h2,
    RES_FOUR      = 2'h3
  } res_e;
  localparam logic [6:0] STEP_SIXTEENTH = 7'h01;
  localparam logic [6:0] STEP_QUARTER   = 7'h04;
  localparam logic [6:0] STEP_ONE       = 7'h10;
  localparam logic [6:0] STEP_FOUR      = 7'h40;

  // Supply supervisor states, Gray along power-up
  typedef enum logic [1:0] {
    SUP_DOWN    = 2'h0,
    SUP_RECOVER = 2'h1,
    SUP_ACCESS  = 2'h3,
    SUP_RUN     = 2'h2
  } sup_e;

  // Pin synchroniser reset: bus strobes idle high, supply above battery,
  // so the reset pin is not let go while the stages flush
  localparam logic [17:0] PIN_SYNC_RST = 18'h3C001;
endpackage

// ===== pin_sync3.sv
// Three-stage synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to i_clk; output settles when the
// second and third stages agree.
`timescale 1ns/10ps
module pin_sync3 #(
  parameter int unsigned W       = 18,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // First stage feeds only the second; agreement filter is on 2 and 3
  always_comb begin
    st_d    = st_q;
    st_d.s1 = i_d;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    st_d.q  = (~(st_q.s2 ^ st_q.s3) & st_q.s3) |
              ((st_q.s2 ^ st_q.s3) & st_q.q);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, q: RST_VAL};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_q = st_q.q;
endmodule

// ===== rtc_watchdog_supervisor.sv
// Timeout timer and supply supervisor behind the parallel clock port.
// Assumes pins are asynchronous, i_rst marks power application, and the
// supply comparators arrive as plain logic levels.
`timescale 1ns/10ps
module rtc_watchdog_supervisor
  import rtc_wd_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC,
  parameter int unsigned REC_CYCLES  = REC_MS * CYC_PER_MS,
  parameter int unsigned RPU_CYCLES  = RPU_MS * CYC_PER_MS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cs_n,
  input  wire logic       i_ce_n,
  input  wire logic       i_we_n,
  input  wire logic       i_oe_n,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_dq,
  input  wire logic       i_supply_ok,
  input  wire logic       i_supply_above_batt,
  input  wire logic       i_alarm_match,
  output logic      [7:0] o_dq,
  output logic            o_dq_oe,
  output logic            o_irq_out,
  output logic            o_irq_oe,
  output logic            o_rst_out,
  output logic            o_rst_oe
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  timeout;
    logic        ae;
    logic        abe;
    logic        wf;
    logic        af;
    logic        wd_irq;
    logic [31:0] tick_cnt;
    logic [10:0] wd_cnt;
    sup_e        sup;
    logic [31:0] sup_cnt;
    logic        prev_rd;
    logic        prev_wr;
    logic [3:0]  cyc_addr;
    logic [7:0]  wr_data;
    logic [7:0]  dq;
    logic        dq_oe;
    logic        irq_oe;
    logic        rst_oe;
    logic        od_low;
  } st_s;

  st_s st_q;
  st_s st_d;

  logic [17:0] pins;
  logic        cs_n, ce_n, we_n, oe_n, sup_ok, above_batt;
  logic [3:0]  addr;
  logic [7:0]  dq_in;

  pin_sync3 #(.W(18), .RST_VAL(PIN_SYNC_RST)) u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_cs_n, i_ce_n, i_we_n, i_oe_n, i_addr, i_dq,
             i_supply_ok, i_supply_above_batt}),
    .o_q   (pins)
  );
  assign {cs_n, ce_n, we_n, oe_n, addr, dq_in, sup_ok, above_batt} = pins;

  // ---------------------------------------------------------------
  // Interval in ticks
  // ---------------------------------------------------------------
  function automatic logic [10:0] interval_of(input logic [7:0] s);
    logic [6:0] step;
    logic [4:0] mult;
    step = STEP_SIXTEENTH;
    mult = s[TO_MULT_LSB +: TO_MULT_W];
    case (res_e'(s[TO_RES_LSB +: 2]))
      RES_SIXTEENTH: step = STEP_SIXTEENTH;
      RES_QUARTER:   step = STEP_QUARTER;
      RES_ONE:       step = STEP_ONE;
      RES_FOUR:      step = STEP_FOUR;
      default:       step = STEP_SIXTEENTH;
    endcase
    return 11'(mult) * 11'(step);
  endfunction

  logic        access_ok, rd_now, wr_now, rd_end, wr_end;
  logic        to_access, flag_read, tick, expire;
  logic [10:0] interval;

  assign access_ok = (st_q.sup == SUP_ACCESS) || (st_q.sup == SUP_RUN);
  // Both selects low is illegal for the host; clock side then stays idle
  assign rd_now = access_ok && !cs_n && ce_n && we_n && !oe_n;
  assign wr_now = access_ok && !cs_n && ce_n && !we_n;
  assign rd_end = st_q.prev_rd && !rd_now && access_ok;
  assign wr_end = st_q.prev_wr && !wr_now && access_ok;
  assign to_access = (rd_end || wr_end) && st_q.cyc_addr == ADDR_TIMEOUT;
  assign flag_read = rd_end && st_q.cyc_addr == ADDR_FLAGS;
  assign interval  = interval_of(st_q.timeout);
  assign tick      = st_q.tick_cnt == 32'(TICK_CYCLES - 1);
  assign expire    = tick && interval != 11'h000 &&
                     st_q.wd_cnt == interval - 11'h001;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d         = st_q;
    st_d.prev_rd = rd_now;
    st_d.prev_wr = wr_now;
    if (rd_now || wr_now) begin
      st_d.cyc_addr = addr;
    end
    if (wr_now) begin
      // Data is taken as it stands at the end of the write strobe
      st_d.wr_data = dq_in;
    end

    if (wr_end && st_q.cyc_addr == ADDR_TIMEOUT) begin
      st_d.timeout = st_q.wr_data;
    end
    if (wr_end && st_q.cyc_addr == ADDR_INTR) begin
      st_d.ae  = st_q.wr_data[INTR_AE_BIT];
      st_d.abe = st_q.wr_data[INTR_ABE_BIT];
    end

    // Time base and timeout count
    if (to_access || interval == 11'h000) begin
      st_d.tick_cnt = 32'h0000_0000;
      st_d.wd_cnt   = 11'h000;
    end else if (tick) begin
      st_d.tick_cnt = 32'h0000_0000;
      st_d.wd_cnt   = expire ? 11'h000 : st_q.wd_cnt + 11'h001;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 32'h0000_0001;
    end

    // Flags: a new event wins over a clear in the same cycle
    if (flag_read) begin
      st_d.wf = 1'b0;
      st_d.af = 1'b0;
    end
    if (flag_read || to_access) begin
      st_d.wd_irq = 1'b0;
    end
    if (expire) begin
      st_d.wf     = 1'b1;
      st_d.wd_irq = 1'b1;
    end
    if (i_alarm_match) begin
      st_d.af = 1'b1;
    end

    // Supply supervisor
    case (st_q.sup)
      SUP_DOWN: begin
        st_d.sup_cnt = 32'h0000_0000;
        if (sup_ok) begin
          st_d.sup = SUP_RECOVER;
        end
      end
      SUP_RECOVER: begin
        st_d.sup_cnt = st_q.sup_cnt + 32'h0000_0001;
        if (st_q.sup_cnt >= 32'(REC_CYCLES - 1)) begin
          st_d.sup = SUP_ACCESS;
        end
      end
      SUP_ACCESS: begin
        st_d.sup_cnt = st_q.sup_cnt + 32'h0000_0001;
        if (st_q.sup_cnt >= 32'(RPU_CYCLES - 1)) begin
          st_d.sup = SUP_RUN;
        end
      end
      SUP_RUN: st_d.sup = SUP_RUN;
      default: st_d.sup = SUP_DOWN;
    endcase
    if (!sup_ok) begin
      st_d.sup     = SUP_DOWN;
      st_d.sup_cnt = 32'h0000_0000;
    end

    // Read data; released whenever access is not allowed
    st_d.dq_oe = rd_now;
    case (addr)
      ADDR_FLAGS:   st_d.dq = {st_q.wf, st_q.af, 6'h00};
      ADDR_INTR:    st_d.dq = {st_q.ae, st_q.abe, 6'h00};
      ADDR_TIMEOUT: st_d.dq = st_q.timeout;
      default:      st_d.dq = 8'h00;
    endcase

    // Open-drain pins only ever pull low
    st_d.irq_oe = (st_q.wd_irq && !st_q.timeout[TO_STEER_BIT]) ||
                  (st_q.af && st_q.ae);
    // Without battery-level supply the pin is unpowered and floats
    st_d.rst_oe = above_batt && (st_q.sup != SUP_RUN);
    st_d.od_low = 1'b0;
  end

  // is for software; the oscillator is outside this block.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q         <= '0;
      st_q.timeout <= TIMEOUT_RST;
      st_q.sup     <= SUP_DOWN;
      st_q.rst_oe  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_dq      = st_q.dq;
  assign o_dq_oe   = st_q.dq_oe;
  assign o_irq_out = st_q.od_low;
  assign o_irq_oe  = st_q.irq_oe;
  assign o_rst_out = st_q.od_low;
  assign o_rst_oe  = st_q.rst_oe;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_supply_rise;
    !sup_ok ##1 sup_ok;
  endsequence
  sequence s_held_off;
    !access_ok [*8];
  endsequence

  a_expiry_flag: assert property (expire |=> st_q.wf && st_q.wd_irq)
    else $error("Expiry did not set flag and interrupt");
  a_irq_hold: assert property (
    st_q.wd_irq && !flag_read && !to_access |=> st_q.wd_irq)
    else $error("Timeout interrupt dropped early");
  a_steer_route: assert property (
    st_q.wd_irq && !st_q.timeout[TO_STEER_BIT] |=> o_irq_oe)
    else $error("Expiry not routed to interrupt pin");
  a_access_restart: assert property (
    to_access |=> st_q.wd_cnt == 11'h000 && st_q.tick_cnt == 32'h0)
    else $error("Register access did not restart timer");
  a_zero_disables: assert property (
    st_q.timeout == 8'h00 |-> !expire)
    else $error("Disabled timer expired");
  a_por_clear: assert property (
    disable iff (1'b0) i_rst |=> st_q.timeout == 8'h00 && !st_q.ae
      && !st_q.abe)
    else $error("Power-up did not clear settings");
  a_protect_release: assert property (!access_ok |=> !o_dq_oe)
    else $error("Data driven while write protected");
  a_recover_wait: assert property (
    s_supply_rise ##0 (REC_CYCLES >= 9) |=> s_held_off)
    else $error("Access allowed before recovery time");
  a_reset_low: assert property (
    (!sup_ok && above_batt) ##1 above_batt |=> o_rst_oe)
    else $error("Reset not driven while supply low");
  a_reset_release: assert property (
    $rose(st_q.sup == SUP_RUN) |-> $past(st_q.sup) == SUP_ACCESS
      && $past(st_q.sup_cnt) >= 32'(RPU_CYCLES - 1))
    else $error("Reset released before timeout period");
  a_alarm_route: assert property (st_q.af && st_q.ae |=> o_irq_oe)
    else $error("Alarm not routed to interrupt pin");
endmodule

// ===== host_bus.sv
// Host processor model driving the parallel clock port pins.
// Assumes the block synchronises the pins; strobes are held six clocks.
`timescale 1ns/10ps
module host_bus
  import rtc_wd_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dq,
  input  wire logic       i_dq_oe,
  output logic            o_cs_n,
  output logic            o_ce_n,
  output logic            o_we_n,
  output logic            o_oe_n,
  output logic      [3:0] o_addr,
  output logic      [7:0] o_dq
);
  // ---------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------
  initial begin
    o_cs_n = 1'b1;
    o_ce_n = 1'b1;
    o_we_n = 1'b1;
    o_oe_n = 1'b1;
    o_addr = 4'hF;
    o_dq   = 8'hA5;
  end

  // Memory enable never drops, so selects cannot overlap
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    // Only the timeout register carries the steering bit
    o_dq   <= (a == ADDR_TIMEOUT) ? (d & 8'h7F) : d;
    o_cs_n <= 1'b0;
    o_we_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_we_n <= 1'b1;
    repeat (2) @(posedge i_clk);
    // Released bus shows the inverse, not a stale copy
    o_dq   <= ~d;
    repeat (4) @(posedge i_clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge i_clk);
    o_addr <= a;
    o_cs_n <= 1'b0;
    o_oe_n <= 1'b0;
    repeat (6) @(posedge i_clk);
    ok = i_dq_oe;
    // An undriven bus reads back as the inverse, never a stale copy
    d  = i_dq_oe ? i_dq : ~i_dq;
    o_cs_n <= 1'b1;
    o_oe_n <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the timeout timer and supply supervisor.
// Assumes shortened tick, recovery and reset periods set below.
`timescale 1ns/10ps
module tb;
  import rtc_wd_pkg::*;
  localparam int unsigned TK = 10;
  logic       i_clk, i_rst, sup_ok, above_batt, alarm, seen, ok;
  logic       cs_n, ce_n, we_n, oe_n, dq_oe, irq_out, irq_oe;
  logic       rst_out, rst_oe;
  logic [3:0] addr;
  logic [7:0] wdat, rdat, d;
  int         n_mismatch, compares, cyc, t0;

  host_bus host (.i_clk(i_clk), .i_dq(rdat), .i_dq_oe(dq_oe),
    .o_cs_n(cs_n), .o_ce_n(ce_n), .o_we_n(we_n), .o_oe_n(oe_n),
    .o_addr(addr), .o_dq(wdat));

  rtc_watchdog_supervisor #(.TICK_CYCLES(TK), .REC_CYCLES(16),
    .RPU_CYCLES(40)) i_rtc_watchdog_supervisor (.i_clk(i_clk),
    .i_rst(i_rst), .i_cs_n(cs_n), .i_ce_n(ce_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_addr(addr), .i_dq(wdat), .i_supply_ok(sup_ok),
    .i_supply_above_batt(above_batt), .i_alarm_match(alarm),
    .o_dq(rdat), .o_dq_oe(dq_oe), .o_irq_out(irq_out),
    .o_irq_oe(irq_oe), .o_rst_out(rst_out), .o_rst_oe(rst_oe));

  // ---------------------------------------------------------------
  // Clock, watch and report
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (irq_oe === 1'b1) seen = 1'b1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Access refused until recovery ends; reset pin lags further
  task automatic pwr_up;
    @(posedge i_clk);
    sup_ok     <= 1'b1;
    above_batt <= 1'b1;
    host.rd(ADDR_TIMEOUT, d, ok);
    chk(ok, 1'b0, "early access");
    idle(2);
    chk(rst_oe, 1'b1, "reset early");
    idle(50);
    chk(rst_oe, 1'b0, "reset held");
  endtask

  // Tick phase restarts at the timeout write; the window is TK+8 cycles wide for bus and sync delay
  task automatic run_to(input logic [7:0] v);
    int n;
    n  = v[6:2] * (1 << (2 * v[1:0]));
    t0 = cyc;
    host.wr(ADDR_TIMEOUT, v);
    while (irq_oe !== 1'b1 && cyc - t0 < n * TK + 40) @(posedge i_clk);
    chk(8'(cyc - t0 >= (n - 1) * TK + 10 && cyc - t0 <= n * TK + 18),
        8'h01, "interval");
    host.rd(ADDR_FLAGS, d, ok);
    chk(d & 8'h80, 8'h80, "timeout flag");
    idle(1);
    chk(irq_oe, 1'b0, "irq clear");
    // Stop the timer before its next expiry can meet the next write
    host.wr(ADDR_TIMEOUT, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] vals [5] = '{8'h0C, 8'h05, 8'h06, 8'h07, 8'h7C};
    n_mismatch = 0;
    compares = 0;
    cyc = 0;
    seen = 1'b0;
    i_rst = 1'b1;
    sup_ok = 1'b0;
    above_batt = 1'b1;
    alarm = 1'b0;
    idle(2);
    i_rst <= 1'b0;
    idle(3);
    chk(rst_oe, 1'b1, "reset low");
    pwr_up;
    host.rd(ADDR_TIMEOUT, d, ok);
    chk(d, TIMEOUT_RST, "timeout reset");
    host.rd(ADDR_INTR, d, ok);
    chk(d, 8'h00, "enables reset");
    $display("test power_up done");
    foreach (vals[i]) run_to(vals[i]);
    $display("test interval done");
    host.wr(ADDR_TIMEOUT, 8'h05);
    seen = 1'b0;
    repeat (6) host.rd(ADDR_TIMEOUT, d, ok);
    chk(d, 8'h05, "readback");
    chk(seen, 1'b0, "restart");
    $display("test restart done");
    foreach (vals[i]) begin
      if (i < 2) begin
        host.wr(ADDR_TIMEOUT, 8'h03 * i[7:0]);
        seen = 1'b0;
        idle(300);
        chk(seen, 1'b0, "disabled");
      end
    end
    $display("test disable done");
    host.wr(ADDR_INTR, 8'hC0);
    host.rd(ADDR_INTR, d, ok);
    chk(d, 8'hC0, "enables");
    alarm <= 1'b1;
    idle(1);
    alarm <= 1'b0;
    idle(3);
    chk(irq_oe, 1'b1, "alarm irq");
    host.rd(ADDR_FLAGS, d, ok);
    chk(d & 8'h40, 8'h40, "alarm flag");
    host.wr(ADDR_INTR, 8'h00);
    alarm <= 1'b1;
    idle(1);
    alarm <= 1'b0;
    idle(4);
    chk(irq_oe, 1'b0, "alarm masked");
    $display("test alarm done");
    host.wr(ADDR_TIMEOUT, 8'h05);
    sup_ok <= 1'b0;
    idle(8);
    chk(rst_oe, 1'b1, "supply trip");
    host.wr(ADDR_TIMEOUT, 8'h06);
    host.rd(ADDR_TIMEOUT, d, ok);
    chk(ok, 1'b0, "outputs off");
    above_batt <= 1'b0;
    idle(8);
    chk(rst_oe, 1'b0, "below battery");
    pwr_up;
    host.rd(ADDR_TIMEOUT, d, ok);
    chk(d, 8'h05, "write blocked");
    host.rd(4'h9, d, ok);
    chk(d, 8'h00, "unmapped");
    chk({irq_out, rst_out}, 2'b00, "open drain");
    $display("test supply done");
    end_sim;
  end
endmodule
